// ### system_clock_prescaler.sv
// System clock prescaler with unlock-guarded select and oscillator trim
`timescale 1ns/1ps
`default_nettype none

module system_clock_prescaler (
  input  wire logic                                  CLK_I,
  input  wire logic                                  RST_I,
  input  wire logic [clock_prescaler_pkg::ADDR_W-1:0] ADDR_I,
  input  wire logic [clock_prescaler_pkg::DATA_W-1:0] WDATA_I,
  input  wire logic                                  WR_I,
  input  wire logic                                  RD_I,
  input  wire logic [clock_prescaler_pkg::DATA_W-1:0] FACTORY_TRIM_I,
  input  wire logic                                  DIV8_FUSE_I,
  input  wire logic                                  CLK_OUT_FUSE_I,
  output logic [clock_prescaler_pkg::DATA_W-1:0]      RDATA_O,
  output logic                                       SYS_CLK_O,
  output logic                                       SYS_TICK_O,
  output logic                                       CLK_OUT_O,
  output logic                                       CLK_OUT_OE_O,
  output logic                                       TRIM_RANGE_O,
  output logic [clock_prescaler_pkg::TRIM_FINE_W-1:0] TRIM_FINE_O,
  output logic [clock_prescaler_pkg::SEL_W-1:0]       DIV_SELECT_O
);

  // Register storage
  logic [clock_prescaler_pkg::DATA_W-1:0]  trim_q;
  logic [clock_prescaler_pkg::SEL_W-1:0]   select_q;
  logic [clock_prescaler_pkg::SEL_W-1:0]   pending_q;
  logic [clock_prescaler_pkg::SEL_W-1:0]   active_q;
  logic [clock_prescaler_pkg::COUNT_W-1:0] limit_q;
  logic [clock_prescaler_pkg::COUNT_W-1:0] limit_d;
  clock_prescaler_pkg::switch_state_t      state_q;
  clock_prescaler_pkg::switch_state_t      state_d;

  // Bus decode
  logic wr_divide;
  logic wr_trim;
  logic unlock_req;
  logic select_wr;
  logic select_ok;
  logic unlock_active;
  logic [clock_prescaler_pkg::DATA_W-1:0] rdata_d;
  logic [clock_prescaler_pkg::DATA_W-1:0] divide_view;
  logic [clock_prescaler_pkg::DATA_W-1:0] status_view;

  // Divider taps
  logic boundary;
  logic level;
  logic busy;

  // Output stage
  logic sys_clk_q;
  logic sys_tick_q;
  logic clk_out_q;
  logic clk_out_oe_q;
  logic rdata_valid;
  logic [clock_prescaler_pkg::DATA_W-1:0] rdata_q;

  // Map a select code to the terminal count of the divider
  function automatic logic [clock_prescaler_pkg::COUNT_W-1:0] sel_limit(
    input logic [clock_prescaler_pkg::SEL_W-1:0] sel
  );
    logic [clock_prescaler_pkg::SEL_W-1:0]   eff;
    logic [clock_prescaler_pkg::COUNT_W:0]   span;
    eff = sel;
    // Reserved codes fall back to the slowest defined factor
    if (sel > clock_prescaler_pkg::SEL_MAX) begin
      eff = clock_prescaler_pkg::SEL_MAX;
    end
    span = ({{clock_prescaler_pkg::COUNT_W{1'b0}}, 1'b1} << eff)
           - {{clock_prescaler_pkg::COUNT_W{1'b0}}, 1'b1};
    return span[clock_prescaler_pkg::COUNT_W-1:0];
  endfunction

  // Write decode
  assign wr_divide = WR_I && (ADDR_I == clock_prescaler_pkg::DIVIDE_OFFSET);
  assign wr_trim   = WR_I && (ADDR_I == clock_prescaler_pkg::TRIM_OFFSET);

  // Unlock only on the exact pattern with every other bit clear
  assign unlock_req = wr_divide
                      && (WDATA_I == clock_prescaler_pkg::UNLOCK_PATTERN);

  // Any divide write that is not the pattern while open closes the window
  assign select_wr = wr_divide && unlock_active
                     && (WDATA_I != clock_prescaler_pkg::UNLOCK_PATTERN);

  // Only a write with the unlock bit zero stores a new select
  assign select_ok = select_wr
                     && !WDATA_I[clock_prescaler_pkg::UNLOCK_BIT];

  unlock_window #(
    .CYCLES (clock_prescaler_pkg::UNLOCK_CYCLES),
    .CNT_W  (clock_prescaler_pkg::UNLOCK_CNT_W)
  ) u_unlock (
    .clk_i    (CLK_I),
    .rst_i    (RST_I),
    .arm_i    (unlock_req),
    .cancel_i (select_wr),
    .active_o (unlock_active)
  );

  // Division select register
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      // Reset value follows the fuse level, caught by the clocked reset
      select_q <= DIV8_FUSE_I ? clock_prescaler_pkg::SEL_DIV8
                              : clock_prescaler_pkg::SEL_DIV1;
    end else if (select_ok) begin
      // No fuse check here: any code is taken once unlocked
      select_q <= WDATA_I[clock_prescaler_pkg::SEL_LSB +:
                          clock_prescaler_pkg::SEL_W];
    end
    // Locked writes fall through and leave the select alone
  end

  // Oscillator trim register
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      trim_q <= FACTORY_TRIM_I;
    end else if (wr_trim) begin
      // Frequency limits during memory writes are up to software
      trim_q <= WDATA_I;
    end
  end

  // Switch sequencer: a new factor is only taken at a period boundary,
  // so the old period always completes and no short pulse can appear.
  always_comb begin
    state_d = state_q;
    limit_d = limit_q;
    unique case (state_q)
      clock_prescaler_pkg::SW_IDLE: begin
        if (select_ok) begin
          state_d = clock_prescaler_pkg::SW_OLD;
        end
      end
      clock_prescaler_pkg::SW_OLD: begin
        if (boundary) begin
          // Old period ends here; the next one runs at the new rate
          limit_d = sel_limit(pending_q);
          if (select_ok) begin
            // A code taken on this edge is not in pending_q yet, so
            // one more boundary must pass before it is applied
            state_d = clock_prescaler_pkg::SW_OLD;
          end else begin
            state_d = clock_prescaler_pkg::SW_NEW;
          end
        end
      end
      clock_prescaler_pkg::SW_NEW: begin
        if (select_ok) begin
          state_d = clock_prescaler_pkg::SW_OLD;
        end else if (boundary) begin
          // Second edge after the write: the new clock is settled
          state_d = clock_prescaler_pkg::SW_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      state_q <= clock_prescaler_pkg::SW_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      limit_q <= sel_limit(DIV8_FUSE_I ? clock_prescaler_pkg::SEL_DIV8
                                       : clock_prescaler_pkg::SEL_DIV1);
    end else begin
      limit_q <= limit_d;
    end
  end

  // Latest requested code, held until the next boundary takes it
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      pending_q <= clock_prescaler_pkg::SEL_DIV1;
    end else if (select_ok) begin
      pending_q <= WDATA_I[clock_prescaler_pkg::SEL_LSB +:
                           clock_prescaler_pkg::SEL_W];
    end
  end

  // Code that the divider is running on right now
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      active_q <= DIV8_FUSE_I ? clock_prescaler_pkg::SEL_DIV8
                              : clock_prescaler_pkg::SEL_DIV1;
    end else if (state_q == clock_prescaler_pkg::SW_OLD && boundary) begin
      active_q <= pending_q;
    end
  end

  assign busy = (state_q != clock_prescaler_pkg::SW_IDLE);

  // Counter runs on every master edge; its count is never visible
  prescale_counter #(
    .W (clock_prescaler_pkg::COUNT_W)
  ) u_counter (
    .clk_i      (CLK_I),
    .rst_i      (RST_I),
    .limit_i    (limit_q),
    .boundary_o (boundary),
    .level_o    (level)
  );

  // Divided system clock level shared by all domains
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      sys_clk_q <= 1'b0;
    end else begin
      // Level lags the count by one cycle, same as the strobe
      sys_clk_q <= level;
    end
  end

  // Active-edge strobe, one master cycle wide except at factor 1, where it stays high
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      sys_tick_q <= 1'b0;
    end else begin
      sys_tick_q <= boundary;
    end
  end

  // Clock output pin enable: released in reset, then follows the fuse
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      clk_out_oe_q <= 1'b0;
    end else begin
      clk_out_oe_q <= CLK_OUT_FUSE_I;
    end
  end

  // Clock output pin level: silent in reset and without the fuse
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      clk_out_q <= 1'b0;
    end else begin
      clk_out_q <= CLK_OUT_FUSE_I && level;
    end
  end

  // Read views
  always_comb begin
    divide_view = '0;
    divide_view[clock_prescaler_pkg::UNLOCK_BIT] = unlock_active;
    divide_view[clock_prescaler_pkg::SEL_LSB +:
                clock_prescaler_pkg::SEL_W] = select_q;
  end

  always_comb begin
    status_view = '0;
    status_view[clock_prescaler_pkg::STAT_BUSY_BIT] = busy;
    status_view[clock_prescaler_pkg::STAT_ACTIVE_LSB +:
                clock_prescaler_pkg::SEL_W] = active_q;
  end

  // Read mux; unmapped addresses answer zero
  always_comb begin
    rdata_d = clock_prescaler_pkg::READ_IDLE;
    if (RD_I) begin
      unique case (ADDR_I)
        clock_prescaler_pkg::DIVIDE_OFFSET: rdata_d = divide_view;
        clock_prescaler_pkg::STATUS_OFFSET: rdata_d = status_view;
        clock_prescaler_pkg::TRIM_OFFSET:   rdata_d = trim_q;
        default:                            rdata_d = '0;
      endcase
    end
  end

  assign rdata_valid = RD_I;

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      rdata_q <= clock_prescaler_pkg::READ_IDLE;
    end else if (rdata_valid) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= clock_prescaler_pkg::READ_IDLE;
    end
  end

  // Trim fields to the oscillator; range overlap is analog behaviour
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      TRIM_RANGE_O <= 1'b0;
    end else begin
      TRIM_RANGE_O <= trim_q[clock_prescaler_pkg::TRIM_RANGE_BIT];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      TRIM_FINE_O <= '0;
    end else begin
      TRIM_FINE_O <= trim_q[clock_prescaler_pkg::TRIM_FINE_W-1:0];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      DIV_SELECT_O <= clock_prescaler_pkg::SEL_DIV1;
    end else begin
      DIV_SELECT_O <= active_q;
    end
  end

  assign RDATA_O      = rdata_q;
  assign SYS_CLK_O    = sys_clk_q;
  assign SYS_TICK_O   = sys_tick_q;
  assign CLK_OUT_O    = clk_out_q;
  assign CLK_OUT_OE_O = clk_out_oe_q;

endmodule
`default_nettype wire

// ### clock_prescaler_pkg.sv
// Constants and types shared by the system clock prescaler files
`default_nettype none
package clock_prescaler_pkg;

  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned SEL_W   = 4;
  localparam int unsigned COUNT_W = 8;

  // Register map, one byte per address
  localparam logic [ADDR_W-1:0] DIVIDE_OFFSET = 8'h26;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h27;
  localparam logic [ADDR_W-1:0] TRIM_OFFSET   = 8'h31;

  // Clock divide register fields
  localparam int unsigned UNLOCK_BIT = 7;
  localparam int unsigned SEL_LSB    = 0;
  localparam logic [DATA_W-1:0] UNLOCK_PATTERN = 8'h80;

  // Status register fields
  localparam int unsigned STAT_BUSY_BIT   = 0;
  localparam int unsigned STAT_ACTIVE_LSB = 4;

  // Trim register fields
  localparam int unsigned TRIM_RANGE_BIT = 7;
  localparam int unsigned TRIM_FINE_W    = 7;

  // Select codes
  localparam logic [SEL_W-1:0] SEL_DIV1 = 4'h0;
  localparam logic [SEL_W-1:0] SEL_DIV8 = 4'h3;
  localparam logic [SEL_W-1:0] SEL_MAX  = 4'h8;

  // Unlock window length in master clock cycles
  localparam int unsigned UNLOCK_CYCLES = 4;
  localparam int unsigned UNLOCK_CNT_W  = 3;

  localparam logic [DATA_W-1:0] READ_IDLE = 8'h00;

  typedef enum logic [2:0] {
    SW_IDLE = 3'b001,
    SW_OLD  = 3'b010,
    SW_NEW  = 3'b100
  } switch_state_t;

endpackage
`default_nettype wire

// ### prescale_counter.sv
// Free running divide counter with period boundary and clock level
`timescale 1ns/1ps
`default_nettype none
module prescale_counter #(
  parameter int unsigned W = 8
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] limit_i,
  output logic              boundary_o,
  output logic              level_o
);

  logic [W-1:0] count_q;
  logic [W-1:0] count_d;
  logic [W:0]   half;

  // Count state stays internal; nothing reads it back
  assign count_d = boundary_o ? '0 : count_q + {{(W-1){1'b0}}, 1'b1};
  assign boundary_o = (count_q == limit_i);
  assign half = ({1'b0, limit_i} + {{W{1'b0}}, 1'b1}) >> 1;
  // High in the first half of each period, always high when undivided
  assign level_o = ({1'b0, count_q} < half) || (limit_i == '0);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

endmodule
`default_nettype wire

// ### unlock_window.sv
// Timed change-unlock flag with a fixed, non-restartable window
`timescale 1ns/1ps
`default_nettype none
module unlock_window #(
  parameter int unsigned CYCLES = 4,
  parameter int unsigned CNT_W  = 3
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic arm_i,
  input  wire logic cancel_i,
  output logic      active_o
);

  logic [CNT_W-1:0] left_q;
  logic             active_q;

  assign active_o = active_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_q <= 1'b0;
      left_q   <= '0;
    end else if (active_q) begin
      // Re-arming inside the window is ignored on purpose
      if (cancel_i || left_q == CNT_W'(1)) begin
        active_q <= 1'b0;
        left_q   <= '0;
      end else begin
        left_q <= left_q - CNT_W'(1);
      end
    end else if (arm_i) begin
      active_q <= 1'b1;
      left_q   <= CNT_W'(CYCLES);
    end
  end

endmodule
`default_nettype wire

// ### prescaler_monitor.sv
// Port checker for the system clock prescaler
`timescale 1ns/1ps
`default_nettype none
module prescaler_monitor (
  input wire logic       CLK_I,
  input wire logic       RST_I,
  input wire logic [7:0] ADDR_I,
  input wire logic       RD_I,
  input wire logic       CLK_OUT_FUSE_I,
  input wire logic [7:0] RDATA_O,
  input wire logic       SYS_TICK_O,
  input wire logic       CLK_OUT_O,
  input wire logic       CLK_OUT_OE_O,
  input wire logic [3:0] DIV_SELECT_O
);
  logic [9:0] gap_q;
  logic       seen_q;
  logic       moved_q;
  logic [3:0] sel_q;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  // Reserved codes run at the slowest rate
  function automatic logic [9:0] fac(input logic [3:0] s);
    return (s > 4'h8) ? 10'h100 : (10'h001 << s);
  endfunction
  // Interval since the last tick; judged exactly only over a steady select
  always_ff @(posedge CLK_I) begin
    if (RST_I || SYS_TICK_O) begin
      gap_q   <= 10'h001;
      seen_q  <= !RST_I;
      moved_q <= 1'b0;
      sel_q   <= DIV_SELECT_O;
    end else begin
      gap_q   <= gap_q + 10'h001;
      moved_q <= moved_q || (DIV_SELECT_O != sel_q);
    end
  end
  a_bits_reserved_zero : assert property (
    RD_I && ADDR_I == clock_prescaler_pkg::DIVIDE_OFFSET
    |=> RDATA_O[6:4] == 3'h0) else $error("reserved bits not zero");
  a_unmapped_reads_zero : assert property (
    RD_I && ADDR_I != clock_prescaler_pkg::DIVIDE_OFFSET
    && ADDR_I != clock_prescaler_pkg::STATUS_OFFSET
    && ADDR_I != clock_prescaler_pkg::TRIM_OFFSET
    |=> RDATA_O == 8'h00) else $error("unmapped read not zero");
  a_read_idle_zero : assert property (
    !RD_I |=> RDATA_O == 8'h00) else $error("read data outside slot");
  a_pin_reset_quiet : assert property (
    disable iff (1'b0) RST_I |=> !CLK_OUT_O && !CLK_OUT_OE_O)
    else $error("clock pin active in reset");
  a_pin_fuse_drive : assert property (
    CLK_OUT_FUSE_I |=> CLK_OUT_OE_O) else $error("pin not driven");
  a_pin_fuse_off : assert property (
    !CLK_OUT_FUSE_I |=> !CLK_OUT_OE_O && !CLK_OUT_O)
    else $error("pin driven without fuse");
  a_tick_exact_period : assert property (
    SYS_TICK_O && seen_q && !moved_q && DIV_SELECT_O == sel_q
    |-> gap_q == fac(sel_q)) else $error("tick period wrong");
  a_switch_never_faster : assert property (
    SYS_TICK_O && seen_q |-> gap_q >= fac(sel_q)
    || gap_q >= fac(DIV_SELECT_O)) else $error("switch too fast");
  a_switch_not_longer : assert property (
    SYS_TICK_O && seen_q
    |-> gap_q <= fac(sel_q) + fac(DIV_SELECT_O))
    else $error("switch period too long");
endmodule
bind system_clock_prescaler prescaler_monitor mon_u (
  .CLK_I(CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .RD_I(RD_I),
  .CLK_OUT_FUSE_I(CLK_OUT_FUSE_I), .RDATA_O(RDATA_O),
  .SYS_TICK_O(SYS_TICK_O), .CLK_OUT_O(CLK_OUT_O),
  .CLK_OUT_OE_O(CLK_OUT_OE_O), .DIV_SELECT_O(DIV_SELECT_O)
);
`default_nettype wire

// ### system_clock_prescaler_tb.sv
// Self-checking bench for the system clock prescaler
`timescale 1ns/1ps
`default_nettype none
module system_clock_prescaler_tb;
  localparam logic [7:0] div_a = clock_prescaler_pkg::DIVIDE_OFFSET;
  localparam logic [7:0] stat_a = clock_prescaler_pkg::STATUS_OFFSET;
  localparam logic [7:0] trim_a = clock_prescaler_pkg::TRIM_OFFSET;
  logic       clk, rst, wr, rd, div8, cko, sys_clk, tick, pin, oe, rng;
  logic [7:0] addr, wdata, ftrim, rdata;
  logic [6:0] fine;
  logic [3:0] sel;
  int         fails, checks_done;
  system_clock_prescaler dut_u (.CLK_I(clk), .RST_I(rst), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .FACTORY_TRIM_I(ftrim),
    .DIV8_FUSE_I(div8), .CLK_OUT_FUSE_I(cko), .RDATA_O(rdata),
    .SYS_CLK_O(sys_clk), .SYS_TICK_O(tick), .CLK_OUT_O(pin),
    .CLK_OUT_OE_O(oe), .TRIM_RANGE_O(rng), .TRIM_FINE_O(fine),
    .DIV_SELECT_O(sel));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic int fa(input logic [3:0] s);
    return (s > 4'h8) ? 256 : (1 << s);
  endfunction
  task automatic chk(input string nm, input logic [15:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc;
    @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, exp, input string nm);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(nm, {8'h00, exp}, {8'h00, rdata});
  endtask
  task automatic t_reset(input logic f, input logic [7:0] t);
    @(posedge clk);
    rst <= 1'b1;
    div8 <= f;
    ftrim <= t;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd_reg(trim_a, t, "trim at reset");
    rd_reg(div_a, f ? 8'h03 : 8'h00, "select at reset");
  endtask
  // The window is four cycles; the last read lands just past it
  task automatic t_window(input logic again);
    wr_reg(div_a, 8'h80);
    if (again) wr_reg(div_a, 8'h80);
    else rd_reg(div_a, 8'h83, "unlock set");
    rd_reg(div_a, 8'h83, "unlock kept");
    rd_reg(div_a, 8'h03, "unlock expired");
  endtask
  task automatic t_lock;
    wr_reg(div_a, 8'h05);
    rd_reg(div_a, 8'h03, "locked select");
    wr_reg(div_a, 8'h81);
    rd_reg(div_a, 8'h03, "unlock with extra bits");
    wr_reg(8'h40, 8'hFF);
    rd_reg(8'h40, 8'h00, "unmapped read");
  endtask
  task automatic t_trim;
    logic [7:0] v;
    for (int i = 0; i < 4; i++) begin
      v = {i[0], {7{i[1]}}};
      wr_reg(trim_a, v);
      rd_reg(trim_a, v, "trim readback");
      chk("trim range", {15'h0, v[7]}, {15'h0, rng});
      chk("trim fine", {9'h0, v[6:0]}, {9'h0, fine});
    end
  endtask
  task automatic t_change(input logic [3:0] c);
    int n;
    int lim;
    lim = fa(sel) + 2 * fa(c) + 4;
    wr_reg(div_a, 8'h80);
    wr_reg(div_a, {4'h0, c});
    n = 0;
    while (sel !== c && n < lim) begin
      cyc;
      n++;
    end
    chk("switch late", 16'h0, {15'h0, n >= lim});
    rd_reg(div_a, {4'h0, c}, "select stored");
    repeat (fa(c) + 4) cyc;
    rd_reg(stat_a, {c, 4'h0}, "status idle");
    n = 0;
    while (tick !== 1'b1 && n < 600) begin
      cyc;
      n++;
    end
    n = 0;
    do begin
      cyc;
      n++;
    end while (tick !== 1'b1 && n < 600);
    chk("tick period", 16'(fa(c)), 16'(n));
  endtask
  // Run at factor four so the pin shows two high of every four cycles
  task automatic t_pin;
    int h;
    int s;
    @(posedge clk);
    cko <= 1'b1;
    repeat (3) cyc;
    h = 0;
    s = 0;
    repeat (16) begin
      cyc;
      h += int'(pin === 1'b1);
      s += int'(sys_clk === 1'b1);
    end
    chk("pin high count", 16'h8, 16'(h));
    chk("system clock high count", 16'h8, 16'(s));
    chk("pin enable", 16'h1, {15'h0, oe});
    @(posedge clk);
    cko <= 1'b0;
    repeat (2) cyc;
    chk("pin released", 16'h0, {14'h0, oe, pin});
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Tests need about 3200 cycles; this allows over seven times that
  initial begin
    #100_000;
    fails++;
    results;
  end
  initial begin
    {rst, div8, ftrim} = {1'b1, 1'b1, 8'hA5};
    {wr, rd, cko, addr, wdata} = '0;
    fails = 0;
    checks_done = 0;
    t_reset(1'b1, 8'hA5);
    t_window(1'b0);
    t_window(1'b1);
    t_lock;
    t_trim;
    for (int c = 0; c < 10; c++) t_change(4'(c));
    t_change(4'h2);
    t_pin;
    t_reset(1'b0, 8'h31);
    results;
  end
endmodule
`default_nettype wire
